// >>> hw/apqco_cfg_if.sv
// Interface: requests from the interpreter to the persistent overlay store
`timescale 1ns/1ns
`default_nettype none
interface apqco_cfg_if;
  import apqco_pkg::*;
  logic restore; // One-cycle pulse: undo all reductions
  logic freeze; // One-cycle pulse: lock overlay commands
  logic set_en; // One-cycle pulse: apply set_caps
  apqco_caps_t set_caps; // Capability words to apply
  logic frozen; // Overlay commands locked
  logic modified; // A reduction is in force
  apqco_caps_t caps; // Capabilities now reported by identify
  modport ctl (output restore, output freeze, output set_en, output set_caps,
    input frozen, input modified, input caps);
  modport store (input restore, input freeze, input set_en, input set_caps,
    output frozen, output modified, output caps);
endinterface : apqco_cfg_if
`default_nettype wire

// >>> hw/apqco_cfg_store.sv
// Persistent overlay state: freeze lock, modified flag, reduced capabilities
`timescale 1ns/1ns
`default_nettype none
module apqco_cfg_store (
  input wire logic sys_clk,
  input wire logic power_rst,
  apqco_cfg_if.store cfg
);
  import apqco_pkg::*;

  // ==========================================================
  // State
  typedef struct packed {
    logic frozen; // Freeze lock in force
    logic modified; // Set has reduced capabilities
    apqco_caps_t caps; // Reported capability words
  } apqco_store_s;

  apqco_store_s st_ff; // Registered state
  apqco_store_s nxt_st; // Next state

  // ==========================================================
  // Next state
  always_comb begin
    nxt_st = st_ff;
    // Restore returns to the full set
    if (cfg.restore) begin
      nxt_st.caps = FULL_CAPS;
      nxt_st.modified = 1'b0;
    end
    // Only bits present in the full set can stay set
    if (cfg.set_en) begin
      nxt_st.caps = cfg.set_caps & FULL_CAPS;
      nxt_st.modified = 1'b1;
    end
    if (cfg.freeze) begin
      nxt_st.frozen = 1'b1;
    end
  end

  // ==========================================================
  // Register, cleared only by loss of power, never by the drive
  // reset, so a lock survives hardware and software resets
  always_ff @(posedge sys_clk) begin
    if (power_rst) begin
      st_ff <= '{frozen: 1'b0, modified: 1'b0, caps: FULL_CAPS};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign cfg.frozen = st_ff.frozen;
  assign cfg.modified = st_ff.modified;
  assign cfg.caps = st_ff.caps;
endmodule // apqco_cfg_store
`default_nettype wire

// >>> hw/apqco_pkg.sv
// Package: constants and types for the power query and config overlay block
package apqco_pkg;
  // ==========================================================
  // Task file register addresses (host write side)
  localparam logic [2:0] REG_FEATURE = 3'h1;
  localparam logic [2:0] REG_SEC_CNT = 3'h2;
  localparam logic [2:0] REG_CYL_LO = 3'h4;
  localparam logic [2:0] REG_CYL_HI = 3'h5;
  localparam logic [2:0] REG_DEV_HEAD = 3'h6;
  localparam logic [2:0] REG_COMMAND = 3'h7;
  // ==========================================================
  // Opcodes and overlay subcommands
  localparam logic [7:0] OP_PWR_QUERY = 8'hE5;
  localparam logic [7:0] OP_PWR_QUERY_ALT = 8'h98;
  localparam logic [7:0] OP_OVERLAY = 8'hB1;
  localparam logic [7:0] SUB_RESTORE = 8'hC0;
  localparam logic [7:0] SUB_FREEZE = 8'hC1;
  localparam logic [7:0] SUB_IDENTIFY = 8'hC2;
  localparam logic [7:0] SUB_SET = 8'hC3;
  // ==========================================================
  // Abort reason codes, reported in sector count
  localparam logic [7:0] RSN_FROZEN = 8'h01;
  localparam logic [7:0] RSN_SEC_LOCKED = 8'h02;
  localparam logic [7:0] RSN_MODIFIED = 8'h03;
  localparam logic [7:0] RSN_DISABLE_EN = 8'h04;
  localparam logic [7:0] RSN_MAX_LOCKED = 8'h05;
  localparam logic [7:0] RSN_PROT_AREA = 8'h06;
  localparam logic [7:0] RSN_UNSUPPORTED = 8'h07;
  localparam logic [7:0] RSN_BAD_SUB = 8'h08;
  localparam logic [7:0] RSN_OTHER = 8'hFF;
  // ==========================================================
  // Power query answers
  localparam logic [7:0] PWR_ACTIVE = 8'hFF;
  localparam logic [7:0] PWR_IDLE = 8'h00;
  // ==========================================================
  // Field positions
  localparam int ERR_ABORT_BIT = 2;
  localparam int DEV_SEL_BIT = 4;
  // ==========================================================
  // Overlay structure layout, 256 words
  localparam logic [7:0] WORD_REVISION = 8'h00;
  localparam logic [15:0] REVISION_VAL = 16'h0001;
  localparam logic [7:0] WORD_LAST = 8'hFF;
  localparam logic [7:0] SIGNATURE = 8'hA5;
  localparam logic [7:0] WORD_MAX_LBA = 8'h03;
  localparam int NUM_CAPS = 5;
  // Identify words whose capability bits may be reduced
  localparam logic [7:0] CAP_IDENT_WORD [NUM_CAPS] = '{8'd63, 8'd82, 8'd83, 8'd84, 8'd88};
  // Structure word holding each of them
  localparam logic [7:0] CAP_OVL_WORD [NUM_CAPS] = '{8'h08, 8'h09, 8'h0A, 8'h0B, 8'h0C};
  // Slot of identify word 82 (feature sets) in the cap array
  localparam int CAP_FEAT_SLOT = 1;
  typedef logic [NUM_CAPS-1:0][15:0] apqco_caps_t;
  // Full selectable capability set, arbitrary defaults
  localparam apqco_caps_t FULL_CAPS = {16'h003F, 16'h4000, 16'h4000, 16'h7000, 16'h0407};
  // Reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [15:0] RST_WORD = 16'h0000;
endpackage : apqco_pkg

// >>> hw/apqco_top.sv
// Top: power query and configuration overlay command interpreter
// Overview of operation
// - Power query accepted under both opcodes alike
// - Sector count FFh when spun up and not in standby or sleep, else 00h
// - Status and error final when interrupt raised
// - Feature register selects overlay subcommand C0h-C3h
// - Restore cancels reductions, full capabilities return
// - After freeze, every overlay subcommand aborts
// - Freeze survives resets, cleared by power loss
// - Identify sends 512-byte block by PIO in
// - Identify shows reduced set, overlay shows full
// - Set alters only words 63,82,83,84,88
// - Cleared capability bit withdraws that feature
// - Bits absent from full set are ignored
// - Restriction break aborts with reason, word, bit
// - Protected area: abort, word 3, reason 06h
// - Reason codes 01h-08h and FFh
// - Last word: A5h signature, zero-sum checksum
`timescale 1ns/1ns
`default_nettype none
module apqco_top #(
  parameter logic DRIVE_SEL = 1'b0 // Device bit value this drive answers to
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic power_rst,
  input wire logic reg_wr,
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic status_rd,
  output logic [7:0] sec_cnt,
  output logic [7:0] cyl_lo,
  output logic [7:0] cyl_hi,
  output logic [7:0] command_error_flags,
  output logic [7:0] device_status_flags,
  output logic intrq,
  output logic [15:0] pio_rdata,
  output logic pio_rvalid,
  input wire logic pio_rready,
  input wire logic [15:0] pio_wdata,
  input wire logic pio_wvalid,
  output logic pio_wready,
  input wire logic spindle_at_speed,
  input wire logic standby_active,
  input wire logic sleep_active,
  input wire logic security_locked,
  input wire logic hpa_established,
  input wire logic max_addr_locked,
  input wire logic [15:0] feat_enabled,
  output apqco_pkg::apqco_caps_t ident_caps
);
  import apqco_pkg::*;

  // ==========================================================
  // Types and state
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_SEND,
    ST_RECV,
    ST_APPLY
  } apqco_st_e;

  typedef struct packed {
    apqco_st_e st; // Command phase
    logic [7:0] feat; // Feature register
    logic [7:0] dev_head; // Device/head register
    logic [7:0] sec_cnt; // Sector count, also reason code
    logic [7:0] cyl_lo; // Cylinder low, also bit index
    logic [7:0] cyl_hi; // Cylinder high, also word index
    logic abort; // Abort bit of the error register
    logic err; // Error bit of the status register
    logic intrq; // Host interrupt level
    logic [7:0] idx; // Word counter of a PIO transfer
    logic [7:0] sum; // Running byte sum of the structure
    logic [15:0] rword; // Word presented to the host
    apqco_caps_t ovl; // Overlay words captured during set
    logic restore; // Pulse to the store
    logic freeze; // Pulse to the store
    logic set_en; // Pulse to the store
  } apqco_top_s;

  apqco_top_s st_ff; // Registered state
  apqco_top_s nxt_st; // Next state
  logic [15:0] feat_viol; // Enabled feature bits a set would drop

  apqco_cfg_if cfg (); // Link to the persistent store

  // ==========================================================
  // Functions
  // Byte sum of one word, overflow dropped
  function automatic logic [7:0] byte_sum(logic [7:0] acc, logic [15:0] w);
    byte_sum = acc + w[7:0] + w[15:8];
  endfunction

  // Word of the overlay identify structure at a given index;
  // the last word closes the checksum over what was sent
  function automatic logic [15:0] ident_word(logic [7:0] i, logic [7:0] sum);
    ident_word = RST_WORD;
    if (i == WORD_REVISION) begin
      ident_word = REVISION_VAL;
    end
    for (int k = 0; k < NUM_CAPS; k++) begin
      if (i == CAP_OVL_WORD[k]) begin
        ident_word = FULL_CAPS[k];
      end
    end
    if (i == WORD_LAST) begin
      ident_word = {8'h00 - (sum + SIGNATURE), SIGNATURE};
    end
  endfunction

  // Index of the lowest set bit, for error reporting
  function automatic logic [7:0] low_bit(logic [15:0] v);
    low_bit = RST_BYTE;
    for (int k = 15; k >= 0; k--) begin
      if (v[k]) begin
        low_bit = 8'(k);
      end
    end
  endfunction

  // Fail a command with reason, word and bit
  function automatic apqco_top_s fail(apqco_top_s x, logic [7:0] rsn,
    logic [7:0] wrd, logic [7:0] bt);
    fail = x;
    fail.sec_cnt = rsn;
    fail.cyl_hi = wrd;
    fail.cyl_lo = bt;
    fail.abort = 1'b1;
    fail.err = 1'b1;
    fail.intrq = 1'b1;
    fail.st = ST_IDLE;
  endfunction

  // Complete a command without error
  function automatic apqco_top_s pass(apqco_top_s x);
    pass = x;
    pass.abort = 1'b0;
    pass.err = 1'b0;
    pass.intrq = 1'b1;
    pass.st = ST_IDLE;
  endfunction

  // ==========================================================
  // Persistent store, on its own power reset
  apqco_cfg_store u_store (
    .sys_clk(sys_clk),
    .power_rst(power_rst),
    .cfg(cfg.store)
  );

  assign cfg.restore = st_ff.restore;
  assign cfg.freeze = st_ff.freeze;
  assign cfg.set_en = st_ff.set_en;
  assign cfg.set_caps = st_ff.ovl;

  // Set would clear a supported bit of an enabled feature set
  assign feat_viol = feat_enabled & cfg.caps[CAP_FEAT_SLOT]
    & ~st_ff.ovl[CAP_FEAT_SLOT];

  // ==========================================================
  // Command interpreter
  always_comb begin
    nxt_st = st_ff;
    nxt_st.restore = 1'b0;
    nxt_st.freeze = 1'b0;
    nxt_st.set_en = 1'b0;
    // Reading status acknowledges the interrupt
    if (status_rd) begin
      nxt_st.intrq = 1'b0;
    end
    unique case (st_ff.st)
      // Task file writes are taken only while idle
      ST_IDLE: begin
        if (reg_wr) begin
          unique case (reg_addr)
            REG_FEATURE: begin
              nxt_st.feat = reg_wdata;
            end
            REG_SEC_CNT: begin
              nxt_st.sec_cnt = reg_wdata;
            end
            REG_CYL_LO: begin
              nxt_st.cyl_lo = reg_wdata;
            end
            REG_CYL_HI: begin
              nxt_st.cyl_hi = reg_wdata;
            end
            REG_DEV_HEAD: begin
              nxt_st.dev_head = reg_wdata;
            end
            REG_COMMAND: begin
              // Commands for the other drive are not ours
              if (st_ff.dev_head[DEV_SEL_BIT] == DRIVE_SEL) begin
                nxt_st.intrq = 1'b0;
                if (reg_wdata == OP_PWR_QUERY || reg_wdata == OP_PWR_QUERY_ALT) begin
                  nxt_st = pass(nxt_st);
                  nxt_st.sec_cnt = (spindle_at_speed && !standby_active
                    && !sleep_active) ? PWR_ACTIVE : PWR_IDLE;
                end else if (reg_wdata == OP_OVERLAY) begin
                  // Subcommand checks, most basic first
                  if (st_ff.feat < SUB_RESTORE || st_ff.feat > SUB_SET) begin
                    nxt_st = fail(nxt_st, RSN_BAD_SUB, RST_BYTE, RST_BYTE);
                  end else if (cfg.frozen) begin
                    nxt_st = fail(nxt_st, RSN_FROZEN, RST_BYTE, RST_BYTE);
                  end else if (security_locked) begin
                    nxt_st = fail(nxt_st, RSN_SEC_LOCKED, RST_BYTE, RST_BYTE);
                  end else begin
                    unique case (st_ff.feat)
                      SUB_RESTORE: begin
                        if (hpa_established) begin
                          nxt_st = fail(nxt_st, RSN_PROT_AREA, WORD_MAX_LBA, RST_BYTE);
                        end else if (max_addr_locked) begin
                          nxt_st = fail(nxt_st, RSN_MAX_LOCKED, WORD_MAX_LBA, RST_BYTE);
                        end else begin
                          nxt_st = pass(nxt_st);
                          nxt_st.restore = 1'b1;
                        end
                      end
                      SUB_FREEZE: begin
                        nxt_st = pass(nxt_st);
                        nxt_st.freeze = 1'b1;
                      end
                      SUB_IDENTIFY: begin
                        // Present the first word at once
                        nxt_st.st = ST_SEND;
                        nxt_st.idx = RST_BYTE;
                        nxt_st.sum = RST_BYTE;
                        nxt_st.rword = ident_word(RST_BYTE, RST_BYTE);
                      end
                      default: begin
                        // Set: only one reduction may be in force
                        if (cfg.modified) begin
                          nxt_st = fail(nxt_st, RSN_MODIFIED, RST_BYTE, RST_BYTE);
                        end else if (hpa_established) begin
                          nxt_st = fail(nxt_st, RSN_PROT_AREA, WORD_MAX_LBA, RST_BYTE);
                        end else if (max_addr_locked) begin
                          nxt_st = fail(nxt_st, RSN_MAX_LOCKED, WORD_MAX_LBA, RST_BYTE);
                        end else begin
                          nxt_st.st = ST_RECV;
                          nxt_st.idx = RST_BYTE;
                          nxt_st.sum = RST_BYTE;
                          nxt_st.ovl = cfg.caps;
                        end
                      end
                    endcase
                  end
                end
              end
            end
            default: begin
              // Sector number and data port are not used here
            end
          endcase
        end
      end
      // Overlay identify: 256 words to the host
      ST_SEND: begin
        if (pio_rready) begin
          nxt_st.sum = byte_sum(st_ff.sum, st_ff.rword);
          nxt_st.idx = st_ff.idx + 8'h01;
          nxt_st.rword = ident_word(nxt_st.idx, nxt_st.sum);
          if (st_ff.idx == WORD_LAST) begin
            nxt_st = pass(nxt_st);
          end
        end
      end
      // Overlay set: 256 words from the host
      ST_RECV: begin
        if (pio_wvalid) begin
          nxt_st.sum = byte_sum(st_ff.sum, pio_wdata);
          nxt_st.idx = st_ff.idx + 8'h01;
          for (int k = 0; k < NUM_CAPS; k++) begin
            if (st_ff.idx == CAP_OVL_WORD[k]) begin
              nxt_st.ovl[k] = pio_wdata;
            end
          end
          // Bad signature poisons the sum; a bad checksum already leaves it nonzero
          if (st_ff.idx == WORD_LAST) begin
            nxt_st.st = ST_APPLY;
            if (pio_wdata[7:0] != SIGNATURE) begin
              nxt_st.sum = SIGNATURE;
            end
          end
        end
      end
      // Judge the received overlay, then apply it
      default: begin
        if (st_ff.sum != RST_BYTE) begin
          nxt_st = fail(nxt_st, RSN_OTHER, WORD_LAST, RST_BYTE);
        end else if (feat_viol != RST_WORD) begin
          nxt_st = fail(nxt_st, RSN_DISABLE_EN, CAP_IDENT_WORD[CAP_FEAT_SLOT],
            low_bit(feat_viol));
        end else begin
          nxt_st = pass(nxt_st);
          nxt_st.set_en = 1'b1;
        end
      end
    endcase
  end

  // ==========================================================
  // State register
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      st_ff <= '{st: ST_IDLE, feat: RST_BYTE, dev_head: RST_BYTE, sec_cnt: RST_BYTE,
        cyl_lo: RST_BYTE, cyl_hi: RST_BYTE, abort: 1'b0, err: 1'b0, intrq: 1'b0,
        idx: RST_BYTE, sum: RST_BYTE, rword: RST_WORD, ovl: FULL_CAPS,
        restore: 1'b0, freeze: 1'b0, set_en: 1'b0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ==========================================================
  // Outputs
  assign sec_cnt = st_ff.sec_cnt;
  assign cyl_lo = st_ff.cyl_lo;
  assign cyl_hi = st_ff.cyl_hi;
  assign intrq = st_ff.intrq;
  // Error: only the abort bit is ever reported
  assign command_error_flags = {5'h00, st_ff.abort, 2'h0};
  // Status: busy while judging, ready and seek done, DRQ in transfer
  assign device_status_flags = {st_ff.st == ST_APPLY, 1'b1, 1'b0, 1'b1,
    st_ff.st == ST_SEND || st_ff.st == ST_RECV, 2'h0, st_ff.err};
  assign pio_rdata = st_ff.rword;
  assign pio_rvalid = st_ff.st == ST_SEND;
  assign pio_wready = st_ff.st == ST_RECV;
  assign ident_caps = cfg.caps;
endmodule // apqco_top
`default_nettype wire

// >>> verif/apqco_host_model.sv
// Host adapter model: task file, status and PIO
`timescale 1ns/1ns
`default_nettype none
module apqco_host_model
  import apqco_pkg::*;
(
  input wire logic sys_clk,
  input wire logic [15:0] pio_rdata,
  input wire logic pio_rvalid,
  input wire logic pio_wready,
  output logic reg_wr,
  output logic [2:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic status_rd,
  output logic pio_rready,
  output logic [15:0] pio_wdata,
  output logic pio_wvalid
);
  logic [15:0] rd_buf [256]; // Last identify block read
  initial begin
    {reg_wr, status_rd, pio_rready, pio_wvalid} = 4'h0;
    reg_addr = REG_COMMAND;
    {reg_wdata, pio_wdata} = 24'h5AA55A;
  end
  // ==========================================
  // One write; released data is inverted
  task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    reg_wdata <= ~d;
  endtask
  // Feature, drive select, then opcode
  task automatic issue(input logic [7:0] f, input logic dev, input logic [7:0] op);
    wr_reg(REG_FEATURE, f);
    wr_reg(REG_DEV_HEAD, {3'b101, dev, 4'h0});
    wr_reg(REG_COMMAND, op);
  endtask
  task automatic ack;
    @(posedge sys_clk);
    status_rd <= 1'b1;
    @(posedge sys_clk);
    status_rd <= 1'b0;
  endtask
  // Identify read; ready toggles to force stalls
  task automatic read_ident;
    int n;
    n = 0;
    pio_rready <= 1'b1;
    while (n < 256) begin
      @(posedge sys_clk);
      if (pio_rvalid && pio_rready) begin
        rd_buf[n] = pio_rdata;
        n++;
      end
      if (n < 256) pio_rready <= ~pio_rready;
      else pio_rready <= 1'b0;
    end
  endtask
  // Set structure: revision, caps, signature, checksum
  task automatic send_set(input apqco_caps_t caps, input logic [7:0] skew);
    logic [15:0] w;
    logic [7:0] sum;
    sum = 8'h00;
    for (int i = 0; i < 256; i++) begin
      w = (i == 0) ? REVISION_VAL : 16'h0000;
      for (int k = 0; k < NUM_CAPS; k++) begin
        if (i == CAP_OVL_WORD[k]) w = caps[k];
      end
      if (i == 255) w = {8'h00 - sum - SIGNATURE + skew, SIGNATURE};
      sum = sum + w[7:0] + w[15:8];
      pio_wdata <= w;
      pio_wvalid <= 1'b1;
      do @(posedge sys_clk); while (!pio_wready);
    end
    pio_wvalid <= 1'b0;
    pio_wdata <= ~w;
  endtask
endmodule // apqco_host_model
`default_nettype wire

// >>> verif/apqco_top_sva.sv
// Checker: assertions on the interpreter's ports
`timescale 1ns/1ns
`default_nettype none
module apqco_top_sva #(
  parameter logic DRIVE_SEL = 1'b0
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic reg_wr,
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic status_rd,
  input wire logic [7:0] sec_cnt,
  input wire logic [7:0] command_error_flags,
  input wire logic [7:0] device_status_flags,
  input wire logic intrq,
  input wire logic pio_rvalid,
  input wire logic pio_wready,
  input wire logic spindle_at_speed,
  input wire logic standby_active,
  input wire logic sleep_active
);
  import apqco_pkg::*;
  // ==========================================
  // Helper logic
  logic idle; // Neither busy nor in a data phase
  logic take; // Command accepted at this edge
  logic qry; // Accepted command is a power query
  logic [7:0] feat_ff; // Shadow of the feature write
  logic dsel_ff; // Shadow of the device select bit
  assign idle = !device_status_flags[7] && !device_status_flags[3];
  assign take = reg_wr && idle && reg_addr == REG_COMMAND && dsel_ff == DRIVE_SEL;
  assign qry = take && (reg_wdata == OP_PWR_QUERY || reg_wdata == OP_PWR_QUERY_ALT);
  // Shadows skip writes the design ignores
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      feat_ff <= RST_BYTE;
      dsel_ff <= 1'b0;
    end else if (reg_wr && idle && reg_addr == REG_FEATURE) begin
      feat_ff <= reg_wdata;
    end else if (reg_wr && idle && reg_addr == REG_DEV_HEAD) begin
      dsel_ff <= reg_wdata[DEV_SEL_BIT];
    end
  end
  // ==========================================
  // Assertions
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  a_query_answer: assert property (
    qry |=> sec_cnt == ($past(spindle_at_speed && !standby_active && !sleep_active)
      ? PWR_ACTIVE : PWR_IDLE))
    else $error("power query answer wrong");
  a_query_clean: assert property (
    qry |=> intrq && command_error_flags == 8'h00 && !device_status_flags[0])
    else $error("power query flags wrong");
  a_reserved_sub: assert property (
    take && reg_wdata == OP_OVERLAY && (feat_ff < SUB_RESTORE || feat_ff > SUB_SET)
    |=> intrq && sec_cnt == RSN_BAD_SUB && command_error_flags[ERR_ABORT_BIT])
    else $error("reserved subcommand not aborted");
  a_abort_err: assert property (
    $rose(intrq) |-> command_error_flags[ERR_ABORT_BIT] == device_status_flags[0])
    else $error("abort and error bits disagree");
  a_status_fixed: assert property (
    device_status_flags[6:4] == 3'b101 && device_status_flags[2:1] == 2'b00)
    else $error("fixed status bits wrong");
  a_intrq_clear: assert property (
    status_rd && idle && !reg_wr |=> !intrq)
    else $error("interrupt not cleared");
  a_pio_drq: assert property (
    pio_rvalid || pio_wready |-> device_status_flags[3] && !intrq)
    else $error("data phase without request flag");
  a_set_apply: assert property (
    $fell(pio_wready) |-> device_status_flags[7] ##1 intrq)
    else $error("set did not complete after busy");
endmodule // apqco_top_sva
bind apqco_top apqco_top_sva #(.DRIVE_SEL(DRIVE_SEL)) u_sva (.*);
`default_nettype wire

// >>> verif/apqco_top_tb.sv
// Testbench: both commands through the task file
`timescale 1ns/1ns
`default_nettype none
module apqco_top_tb;
  import apqco_pkg::*;
  logic sys_clk, reset, power_rst, spindle_at_speed, standby_active, sleep_active;
  logic security_locked, hpa_established, max_addr_locked;
  logic [15:0] feat_enabled;
  wire logic reg_wr, status_rd, intrq, pio_rvalid, pio_rready, pio_wvalid, pio_wready;
  wire logic [2:0] reg_addr;
  wire logic [7:0] reg_wdata, sec_cnt, cyl_lo, cyl_hi, command_error_flags, device_status_flags;
  wire logic [15:0] pio_rdata, pio_wdata;
  wire apqco_caps_t ident_caps;
  apqco_caps_t red; // Overlay under test
  logic [7:0] rsn [3] = '{RSN_PROT_AREA, RSN_MAX_LOCKED, RSN_SEC_LOCKED};
  int mismatches, checks;
  apqco_top dut (.*);
  apqco_host_model host (.*);
  // ==========================================
  // Checking and closing
  task automatic check(input logic [79:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %0t: saw %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // Wait for completion, check flags and registers
  task automatic done(input logic abt, input logic [7:0] sc, hi = 8'h00, lo = 8'h00,
    input logic [1:0] what = 2'b01);
    int n;
    n = 0;
    while (intrq !== 1'b1 && n < 700) begin
      @(posedge sys_clk);
      n++;
    end
    check(intrq, 1'b1);
    check({command_error_flags, device_status_flags[0]}, {5'h00, abt, 2'b00, abt});
    if (what[0]) check(sec_cnt, sc);
    if (what[1]) check({cyl_hi, cyl_lo}, {hi, lo});
    host.ack();
  endtask
  // Identify always shows the full set
  task automatic ident_ok;
    logic [7:0] sum;
    sum = 8'h00;
    host.issue(SUB_IDENTIFY, 1'b0, OP_OVERLAY);
    host.read_ident();
    for (int i = 0; i < 256; i++) begin
      sum = sum + host.rd_buf[i][7:0] + host.rd_buf[i][15:8];
    end
    check(host.rd_buf[0], REVISION_VAL);
    check({sum, host.rd_buf[255][7:0]}, {8'h00, SIGNATURE});
    for (int k = 0; k < NUM_CAPS; k++) begin
      check(host.rd_buf[CAP_OVL_WORD[k]], FULL_CAPS[k]);
    end
    done(1'b0, 8'h00, 8'h00, 8'h00, 2'b00);
  endtask
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  // Watchdog, far beyond the run's length
  initial begin
    repeat (30000) @(posedge sys_clk);
    mismatches++;
    final_report();
  end
  // ==========================================
  // Main sequence
  initial begin
    {mismatches, checks} = '0;
    {reset, power_rst, spindle_at_speed} = 3'b111;
    {standby_active, sleep_active, security_locked, hpa_established, max_addr_locked} = '0;
    feat_enabled = 16'h0000;
    red = FULL_CAPS;
    repeat (20) @(posedge sys_clk);
    reset <= 1'b0;
    power_rst <= 1'b0;
    @(posedge sys_clk);
    check({intrq, device_status_flags, command_error_flags}, {1'b0, 8'h50, 8'h00});
    check(ident_caps, FULL_CAPS);
    for (int i = 0; i < 16; i++) begin
      {sleep_active, standby_active, spindle_at_speed} <= i[2:0];
      host.issue(8'h00, 1'b0, i[3] ? OP_PWR_QUERY_ALT : OP_PWR_QUERY);
      done(1'b0, (i[2:0] == 3'b001) ? PWR_ACTIVE : PWR_IDLE);
    end
    host.issue(8'h00, 1'b1, OP_PWR_QUERY);
    repeat (4) @(posedge sys_clk);
    check(intrq, 1'b0);
    for (int j = 0; j < 3; j++) begin
      host.issue(8'hBF + 8'(j * 5), 1'b0, OP_OVERLAY);
      done(1'b1, RSN_BAD_SUB);
    end
    ident_ok();
    red[0] = (FULL_CAPS[0] & 16'hFFFB) | 16'h8000;
    host.issue(SUB_SET, 1'b0, OP_OVERLAY);
    host.send_set(red, 8'h00);
    done(1'b0, 8'h00, 8'h00, 8'h00, 2'b00);
    red[0] = FULL_CAPS[0] & 16'hFFFB;
    check(ident_caps, red);
    ident_ok();
    host.issue(SUB_SET, 1'b0, OP_OVERLAY);
    done(1'b1, RSN_MODIFIED);
    host.issue(SUB_RESTORE, 1'b0, OP_OVERLAY);
    done(1'b0, 8'h00, 8'h00, 8'h00, 2'b00);
    check(ident_caps, FULL_CAPS);
    // Clearing an enabled word 82 feature is refused
    feat_enabled <= 16'h1000;
    red = FULL_CAPS;
    red[CAP_FEAT_SLOT] = FULL_CAPS[CAP_FEAT_SLOT] & 16'hEFFF;
    host.issue(SUB_SET, 1'b0, OP_OVERLAY);
    host.send_set(red, 8'h00);
    done(1'b1, RSN_DISABLE_EN, 8'h52, 8'h0C, 2'b11);
    feat_enabled <= 16'h0000;
    host.issue(SUB_SET, 1'b0, OP_OVERLAY);
    host.send_set(FULL_CAPS, 8'h01);
    done(1'b1, RSN_OTHER);
    for (int j = 0; j < 3; j++) begin
      {hpa_established, max_addr_locked, security_locked} <= 3'b100 >> j;
      host.issue(j[1] ? SUB_IDENTIFY : SUB_RESTORE, 1'b0, OP_OVERLAY);
      done(1'b1, rsn[j], 8'h03, 8'h00, (j == 0) ? 2'b11 : 2'b01);
    end
    {hpa_established, max_addr_locked, security_locked} <= 3'b000;
    host.issue(SUB_FREEZE, 1'b0, OP_OVERLAY);
    done(1'b0, 8'h00, 8'h00, 8'h00, 2'b00);
    for (int j = 0; j < 4; j++) begin
      host.issue(SUB_RESTORE + 8'(j), 1'b0, OP_OVERLAY);
      done(1'b1, RSN_FROZEN);
    end
    // Drive reset keeps the lock; power loss clears it
    for (int j = 0; j < 2; j++) begin
      {reset, power_rst} <= {1'b1, j[0]};
      repeat (2) @(posedge sys_clk);
      {reset, power_rst} <= 2'b00;
      host.issue(SUB_RESTORE, 1'b0, OP_OVERLAY);
      done(!j[0], j[0] ? 8'h00 : RSN_FROZEN);
    end
    final_report();
  end
endmodule // apqco_top_tb
`default_nettype wire
